// >>> pkg/pfi_consts.svh
`ifndef PFI_CONSTS_SVH
`define PFI_CONSTS_SVH

// Byte offsets of the six registers
`define PFI_OFF_BUCK_FAULT_FLAGS 8'h00
`define PFI_OFF_BUCK_FAULT_MASKS 8'h04
`define PFI_OFF_BUCK_FAULT_LIVE  8'h08
`define PFI_OFF_MISC_FAULT_FLAGS 8'h0c
`define PFI_OFF_MISC_FAULT_MASKS 8'h10
`define PFI_OFF_MISC_FAULT_LIVE  8'h14
`define PFI_REG_COUNT            6

// Word indices of the registers
`define PFI_IDX_BUCK_FLAGS 3'h0
`define PFI_IDX_BUCK_MASKS 3'h1
`define PFI_IDX_BUCK_LIVE  3'h2
`define PFI_IDX_MISC_FLAGS 3'h3
`define PFI_IDX_MISC_MASKS 3'h4
`define PFI_IDX_MISC_LIVE  3'h5

// Field positions, first group
`define PFI_BIT_BUCK_THREE 4
`define PFI_BIT_BUCK_TWO   3
`define PFI_BIT_BUCK_ONE_B 1
`define PFI_BIT_BUCK_ONE_A 0
`define PFI_BUCK_BITS      8'h1b

// Field positions, second group
`define PFI_BIT_FUSE_ERROR 7
`define PFI_BIT_FUSE_BLOW  6
`define PFI_BIT_INPUT_OV   2
`define PFI_BIT_BOOST      0
`define PFI_MISC_BITS      8'hc5

// Reset values
`define PFI_RST_FLAGS 8'h00
`define PFI_RST_BUCK_MASKS 8'h1b
`define PFI_RST_MISC_MASKS 8'hc5

// Bus response codes
`define PFI_RESP_OKAY   2'h0
`define PFI_RESP_SLVERR 2'h2
`define PFI_RESP_DECERR 2'h3

`endif

// >>> pkg/pfi_pkg.sv
package pfi_pkg;

	// Whole state of the block, registered as one word
	typedef struct packed {
		logic [3:0] buck_meta;   // {three, two, one_b, one_a}
		logic [3:0] buck_sync;
		logic [3:0] misc_meta;   // {fuse error, blow running, input ov, boost}
		logic [3:0] misc_sync;
		logic       blow_prev;
		logic [7:0] buck_flags;
		logic [7:0] buck_masks;
		logic [7:0] misc_flags;
		logic [7:0] misc_masks;
		logic       aw_held;
		logic       aw_hit;
		logic [2:0] aw_idx;
		logic       w_held;
		logic [7:0] w_data;
		logic       w_strb0;
		logic       awready;
		logic       wready;
		logic       bvalid;
		logic [1:0] bresp;
		logic       arready;
		logic       rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic       irq_n;
	} pfi_state_t;

endpackage

// >>> core/pfi_fault_irq.sv
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pfi_consts.svh"

module pfi_fault_irq
	import pfi_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk,                 // 100 MHz clock
	input  wire logic              rst,                 // Async reset, active high
	input  wire logic              buck_one_a_fault,    // Buck one-A in current limit
	input  wire logic              buck_one_b_fault,    // Buck one-B in current limit
	input  wire logic              buck_two_fault,      // Buck two in current limit
	input  wire logic              buck_three_fault,    // Buck three in current limit
	input  wire logic              boost_fault,         // Boost in current limit
	input  wire logic              input_overvoltage,   // Front-end supply overvoltage
	input  wire logic              fuse_memory_error,   // Fuse memory error present
	input  wire logic              fuse_blow_running,   // Fuse-blow sequence running
	output logic                   interrupt_request_pin_n, // Request, active low
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,        // Write address
	input  wire logic              s_axi_awvalid,       // Write address valid
	output logic                   s_axi_awready,       // Write address ready
	input  wire logic [31:0]       s_axi_wdata,         // Write data
	input  wire logic [3:0]        s_axi_wstrb,         // Write strobes
	input  wire logic              s_axi_wvalid,        // Write data valid
	output logic                   s_axi_wready,        // Write data ready
	output logic [1:0]             s_axi_bresp,         // Write response
	output logic                   s_axi_bvalid,        // Write response valid
	input  wire logic              s_axi_bready,        // Write response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,        // Read address
	input  wire logic              s_axi_arvalid,       // Read address valid
	output logic                   s_axi_arready,       // Read address ready
	output logic [31:0]            s_axi_rdata,         // Read data
	output logic [1:0]             s_axi_rresp,         // Read response
	output logic                   s_axi_rvalid,        // Read data valid
	input  wire logic              s_axi_rready         // Read data ready
);

	if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
		$error("pfi_fault_irq: ADDR_W must lie between 5 and 32");
	end

	localparam pfi_state_t ST_RESET = '{
		buck_meta:  4'h0,
		buck_sync:  4'h0,
		misc_meta:  4'h0,
		misc_sync:  4'h0,
		blow_prev:  1'b0,
		buck_flags: `PFI_RST_FLAGS,
		buck_masks: `PFI_RST_BUCK_MASKS,
		misc_flags: `PFI_RST_FLAGS,
		misc_masks: `PFI_RST_MISC_MASKS,
		aw_held:    1'b0,
		aw_hit:     1'b0,
		aw_idx:     3'h0,
		w_held:     1'b0,
		w_data:     8'h00,
		w_strb0:    1'b0,
		awready:    1'b1,
		wready:     1'b1,
		bvalid:     1'b0,
		bresp:      `PFI_RESP_OKAY,
		arready:    1'b1,
		rvalid:     1'b0,
		rresp:      `PFI_RESP_OKAY,
		rdata:      8'h00,
		irq_n:      1'b1
	};

	pfi_state_t st_reg;
	pfi_state_t st_next;

	// Address decode shared by read and write: {hit, word index}
	function automatic logic [3:0] reg_decode(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-3:0] word;
		logic              hit;
		word = addr[ADDR_W-1:2];
		hit  = (addr[1:0] == 2'b00) && (word < (ADDR_W-2)'(`PFI_REG_COUNT));
		return {hit, word[2:0]};
	endfunction

	// Live sense bytes, spread onto the documented bit positions
	function automatic logic [7:0] buck_live_byte(input logic [3:0] s);
		logic [7:0] b;
		b = 8'h00;
		b[`PFI_BIT_BUCK_THREE] = s[3];
		b[`PFI_BIT_BUCK_TWO]   = s[2];
		b[`PFI_BIT_BUCK_ONE_B] = s[1];
		b[`PFI_BIT_BUCK_ONE_A] = s[0];
		return b;
	endfunction

	function automatic logic [7:0] misc_live_byte(input logic [3:0] s);
		logic [7:0] b;
		b = 8'h00;
		b[`PFI_BIT_FUSE_ERROR] = s[3];
		b[`PFI_BIT_FUSE_BLOW]  = s[2];
		b[`PFI_BIT_INPUT_OV]   = s[1];
		b[`PFI_BIT_BOOST]      = s[0];
		return b;
	endfunction

	logic [7:0] buck_live;
	logic [7:0] misc_live;
	logic [7:0] buck_set;
	logic [7:0] misc_set;
	logic [7:0] buck_clr;
	logic [7:0] misc_clr;
	logic       do_write;
	logic       blow_done;

	always_comb begin
		logic [3:0] ar_dec;
		logic [3:0] aw_dec;
		logic [7:0] rd;
		st_next = st_reg;
		ar_dec  = reg_decode(s_axi_araddr);
		aw_dec  = reg_decode(s_axi_awaddr);
		rd      = 8'h00;

		// Fault sources are analog comparators, so two flops each
		st_next.buck_meta = {buck_three_fault, buck_two_fault, buck_one_b_fault, buck_one_a_fault};
		st_next.buck_sync = st_reg.buck_meta;
		st_next.misc_meta = {fuse_memory_error, fuse_blow_running, input_overvoltage, boost_fault};
		st_next.misc_sync = st_reg.misc_meta;
		st_next.blow_prev = st_reg.misc_sync[2];

		buck_live = buck_live_byte(st_reg.buck_sync);
		misc_live = misc_live_byte(st_reg.misc_sync);

		// Level sources set while present; blow-done sets on end of run
		blow_done = st_reg.blow_prev && !st_reg.misc_sync[2];
		buck_set  = buck_live;
		misc_set  = misc_live & ~(8'h01 << `PFI_BIT_FUSE_BLOW);
		misc_set[`PFI_BIT_FUSE_BLOW] = blow_done;

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && st_reg.awready) begin
			st_next.aw_held = 1'b1;
			st_next.aw_hit  = aw_dec[3];
			st_next.aw_idx  = aw_dec[2:0];
		end
		if (s_axi_wvalid && st_reg.wready) begin
			st_next.w_held  = 1'b1;
			st_next.w_data  = s_axi_wdata[7:0];
			st_next.w_strb0 = s_axi_wstrb[0];
		end

		do_write = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
		buck_clr = 8'h00;
		misc_clr = 8'h00;
		if (do_write) begin
			st_next.aw_held = 1'b0;
			st_next.w_held  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = `PFI_RESP_OKAY;
			if (!st_reg.aw_hit) begin
				st_next.bresp = `PFI_RESP_DECERR;
			end else if (st_reg.aw_idx == `PFI_IDX_BUCK_LIVE || st_reg.aw_idx == `PFI_IDX_MISC_LIVE) begin
				st_next.bresp = `PFI_RESP_SLVERR;
			end else if (st_reg.w_strb0) begin
				case (st_reg.aw_idx)
					`PFI_IDX_BUCK_FLAGS: begin
						buck_clr = st_reg.w_data & `PFI_BUCK_BITS;
					end
					`PFI_IDX_MISC_FLAGS: begin
						misc_clr = st_reg.w_data & `PFI_MISC_BITS;
					end
					`PFI_IDX_BUCK_MASKS: begin
						st_next.buck_masks = st_reg.w_data & `PFI_BUCK_BITS;
					end
					`PFI_IDX_MISC_MASKS: begin
						st_next.misc_masks = st_reg.w_data & `PFI_MISC_BITS;
					end
					default: begin
						st_next.bresp = `PFI_RESP_OKAY;
					end
				endcase
			end
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		// One write in flight; each channel reopens once its item is used and the write response is accepted
		st_next.awready = !st_next.aw_held && !st_next.bvalid;
		st_next.wready  = !st_next.w_held && !st_next.bvalid;

		// Set beats a clear arriving in the same cycle
		st_next.buck_flags = (st_reg.buck_flags & ~buck_clr) | buck_set;
		st_next.misc_flags = (st_reg.misc_flags & ~misc_clr) | misc_set;

		// Read channel; reads never disturb the flags, masks or write channel
		if (s_axi_arvalid && st_reg.arready) begin
			case (ar_dec[2:0])
				`PFI_IDX_BUCK_FLAGS: rd = st_reg.buck_flags;
				`PFI_IDX_BUCK_MASKS: rd = st_reg.buck_masks;
				`PFI_IDX_BUCK_LIVE:  rd = buck_live;
				`PFI_IDX_MISC_FLAGS: rd = st_reg.misc_flags;
				`PFI_IDX_MISC_MASKS: rd = st_reg.misc_masks;
				`PFI_IDX_MISC_LIVE:  rd = misc_live;
				default:             rd = 8'h00;
			endcase
			st_next.rdata   = ar_dec[3] ? rd : 8'h00;
			st_next.rresp   = ar_dec[3] ? `PFI_RESP_OKAY : `PFI_RESP_DECERR;
			st_next.rvalid  = 1'b1;
			st_next.arready = 1'b0;
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid  = 1'b0;
			st_next.arready = 1'b1;
		end

		// Pin built from the state being registered, so it never lags a mask write
		// Costs a longer path from the bus decode to the pin flop
		st_next.irq_n = ~(|(st_next.buck_flags & ~st_next.buck_masks)
			| |(st_next.misc_flags & ~st_next.misc_masks));
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign interrupt_request_pin_n = st_reg.irq_n;
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready  = st_reg.wready;
	assign s_axi_bvalid  = st_reg.bvalid;
	assign s_axi_bresp   = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid  = st_reg.rvalid;
	assign s_axi_rresp   = st_reg.rresp;
	assign s_axi_rdata   = {24'h000000, st_reg.rdata};

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic [7:0] buck_pend;
	logic [7:0] misc_pend;
	assign buck_pend = st_reg.buck_flags & ~st_reg.buck_masks;
	assign misc_pend = st_reg.misc_flags & ~st_reg.misc_masks;

	sequence s_write_flags(logic [2:0] idx, logic [7:0] bits);
		do_write && st_reg.aw_hit && st_reg.aw_idx == idx && st_reg.w_strb0 && ((st_reg.w_data & bits) != 8'h00);
	endsequence

	sequence s_blow_ends;
		st_reg.misc_sync[2] ##1 !st_reg.misc_sync[2];
	endsequence

	a_buck_three_set: assert property (
		st_reg.buck_sync[3] |=> st_reg.buck_flags[`PFI_BIT_BUCK_THREE]
	) else $error("buck three fault did not set its flag");

	a_buck_two_set: assert property (
		st_reg.buck_sync[2] |=> st_reg.buck_flags[`PFI_BIT_BUCK_TWO]
	) else $error("buck two fault did not set its flag");

	a_buck_one_b_set: assert property (
		st_reg.buck_sync[1] |=> st_reg.buck_flags[`PFI_BIT_BUCK_ONE_B]
	) else $error("buck one-B fault did not set its flag");

	a_buck_one_a_set: assert property (
		st_reg.buck_sync[0] |=> st_reg.buck_flags[`PFI_BIT_BUCK_ONE_A]
	) else $error("buck one-A fault did not set its flag");

	a_flag_clear_w1c: assert property (
		s_write_flags(`PFI_IDX_BUCK_FLAGS, `PFI_BUCK_BITS) ##0 (buck_set == 8'h00)
		|=> (st_reg.buck_flags & $past(st_reg.w_data)) == 8'h00
	) else $error("write of one did not clear a first-group flag");

	a_flag_sticky: assert property (
		!do_write && (st_reg.misc_flags != 8'h00) |=> (st_reg.misc_flags & $past(st_reg.misc_flags)) == $past(st_reg.misc_flags)
	) else $error("second-group flag dropped without a clearing write");

	a_set_wins_clear: assert property (
		s_write_flags(`PFI_IDX_MISC_FLAGS, `PFI_MISC_BITS) ##0 (misc_set != 8'h00) |=> (st_reg.misc_flags & $past(misc_set)) == $past(misc_set)
	) else $error("clear beat a simultaneous set");

	a_pin_follows: assert property (
		(buck_pend != 8'h00 || misc_pend != 8'h00) |-> !st_reg.irq_n
	) else $error("unmasked flag set but request pin high");

	a_pin_quiet: assert property (
		(buck_pend == 8'h00 && misc_pend == 8'h00) [*2] |-> st_reg.irq_n
	) else $error("request pin low with no unmasked flag");

	a_mask_fields: assert property (
		(st_reg.buck_masks & ~`PFI_BUCK_BITS) == 8'h00 && (st_reg.misc_masks & ~`PFI_MISC_BITS) == 8'h00
	) else $error("mask bit outside its flag positions");

	a_mask_write: assert property (
		do_write && st_reg.aw_hit && st_reg.aw_idx == `PFI_IDX_MISC_MASKS && st_reg.w_strb0
		|=> st_reg.misc_masks == ($past(st_reg.w_data) & `PFI_MISC_BITS)
	) else $error("second mask register did not take written value");

	a_fuse_error_set: assert property (
		st_reg.misc_sync[3] |=> st_reg.misc_flags[`PFI_BIT_FUSE_ERROR]
	) else $error("fuse memory error did not set its flag");

	a_blow_done_set: assert property (
		s_blow_ends |=> st_reg.misc_flags[`PFI_BIT_FUSE_BLOW]
	) else $error("end of fuse blow did not set done flag");

	a_input_ov_set: assert property (
		st_reg.misc_sync[1] |=> st_reg.misc_flags[`PFI_BIT_INPUT_OV]
	) else $error("input overvoltage did not set its flag");

	a_boost_set: assert property (
		st_reg.misc_sync[0] |=> st_reg.misc_flags[`PFI_BIT_BOOST]
	) else $error("boost fault did not set its flag");

	a_live_read: assert property (
		s_axi_arvalid && st_reg.arready && s_axi_araddr == ADDR_W'(`PFI_OFF_MISC_FAULT_LIVE)
		|=> s_axi_rvalid && st_reg.rdata == misc_live_byte($past(st_reg.misc_sync))
	) else $error("second sense read did not return live state");

	a_blow_live: assert property (
		$past(fuse_blow_running, 2) == st_reg.misc_sync[2]
	) else $error("blow running sense not two cycles behind its pin");

	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] st_reg.bvalid
	) else $error("write response did not follow within two cycles");

	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready
	) else $error("read response did not follow one cycle later");

	a_buck_mask_write: assert property (
		do_write && st_reg.aw_hit && st_reg.aw_idx == `PFI_IDX_BUCK_MASKS && st_reg.w_strb0
		|=> st_reg.buck_masks == ($past(st_reg.w_data) & `PFI_BUCK_BITS)
	) else $error("first mask register did not take written value");

	a_live_write_refused: assert property (
		do_write && st_reg.aw_hit
		&& (st_reg.aw_idx == `PFI_IDX_BUCK_LIVE || st_reg.aw_idx == `PFI_IDX_MISC_LIVE)
		|=> st_reg.bvalid && st_reg.bresp == `PFI_RESP_SLVERR
		&& $stable(st_reg.buck_masks) && $stable(st_reg.misc_masks)
	) else $error("write to a sense register was not refused");

	a_strb_ignored: assert property (
		do_write && st_reg.aw_hit && !st_reg.w_strb0
		|=> $stable(st_reg.buck_masks) && $stable(st_reg.misc_masks)
	) else $error("write without low strobe changed a mask");

	a_buck_live_read: assert property (
		s_axi_arvalid && st_reg.arready && s_axi_araddr == ADDR_W'(`PFI_OFF_BUCK_FAULT_LIVE)
		|=> s_axi_rvalid && st_reg.rdata == buck_live_byte($past(st_reg.buck_sync))
	) else $error("first sense read did not return live state");

endmodule

// >>> dv/pfi_host_model.sv
`timescale 1ns/1ps
module pfi_host_model (
	input  wire logic        clk,     // Bus clock
	output logic [7:0]       awaddr,  // Write address
	output logic             awvalid, // Write address valid
	input  wire logic        awready, // Write address ready
	output logic [31:0]      wdata,   // Write data
	output logic [3:0]       wstrb,   // Write strobes
	output logic             wvalid,  // Write data valid
	input  wire logic        wready,  // Write data ready
	input  wire logic [1:0]  bresp,   // Write response
	input  wire logic        bvalid,  // Write response valid
	output logic             bready,  // Write response ready
	output logic [7:0]       araddr,  // Read address
	output logic             arvalid, // Read address valid
	input  wire logic        arready, // Read address ready
	input  wire logic [31:0] rdata,   // Read data
	input  wire logic [1:0]  rresp,   // Read response
	input  wire logic        rvalid,  // Read data valid
	output logic             rready   // Read data ready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// Waits as long as the slave needs; only the bench watchdog ends a hung cycle
	task automatic wr_s(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		wr_s(a, d, 4'h1, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule

// >>> dv/pfi_fault_irq_tb.sv
`timescale 1ns/1ps
`include "pfi_consts.svh"
module pfi_fault_irq_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  bv = 8'h00;
	logic [7:0]  mv = 8'h00;
	logic        pin_n;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          fail_count = 0;
	int          checks_done = 0;

	always #5 clk = ~clk;

	pfi_fault_irq u_pfi_fault_irq (.clk(clk), .rst(rst),
		.buck_one_a_fault(bv[0]), .buck_one_b_fault(bv[1]), .buck_two_fault(bv[3]),
		.buck_three_fault(bv[4]), .boost_fault(mv[0]), .input_overvoltage(mv[2]),
		.fuse_memory_error(mv[7]), .fuse_blow_running(mv[6]), .interrupt_request_pin_n(pin_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	pfi_host_model u_pfi_host_model (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic drive(input logic g, input int b, input logic v);
		@(posedge clk);
		if (g)
			mv[b] <= v;
		else
			bv[b] <= v;
	endtask

	task automatic t_regs();
		logic [7:0]  adr [6] = '{`PFI_OFF_BUCK_FAULT_FLAGS, `PFI_OFF_BUCK_FAULT_MASKS,
			`PFI_OFF_BUCK_FAULT_LIVE, `PFI_OFF_MISC_FAULT_FLAGS, `PFI_OFF_MISC_FAULT_MASKS,
			`PFI_OFF_MISC_FAULT_LIVE};
		logic [7:0]  rv [6] = '{8'h00, 8'h1b, 8'h00, 8'h00, 8'hc5, 8'h00};
		logic [31:0] d;
		logic [1:0]  r;
		chk("pin idle", {31'h0, pin_n}, 32'h1);
		for (int i = 0; i < 6; i++) begin
			u_pfi_host_model.rd(adr[i], d, r);
			chk("reset value", d, {24'h0, rv[i]});
			chk("read resp", {30'h0, r}, {30'h0, `PFI_RESP_OKAY});
		end
		u_pfi_host_model.rd(8'h18, d, r);
		chk("unmapped resp", {30'h0, r}, {30'h0, `PFI_RESP_DECERR});
		u_pfi_host_model.wr(`PFI_OFF_MISC_FAULT_LIVE, 8'hc5, r);
		chk("live write resp", {30'h0, r}, {30'h0, `PFI_RESP_SLVERR});
		u_pfi_host_model.rd(`PFI_OFF_MISC_FAULT_LIVE, d, r);
		chk("live unchanged", d, 32'h0);
		u_pfi_host_model.wr_s(`PFI_OFF_BUCK_FAULT_MASKS, 8'h00, 4'h0, r);
		chk("no strobe resp", {30'h0, r}, {30'h0, `PFI_RESP_OKAY});
		u_pfi_host_model.rd(`PFI_OFF_BUCK_FAULT_MASKS, d, r);
		chk("no strobe mask", d, {24'h0, `PFI_RST_BUCK_MASKS});
		$display("t_regs done");
	endtask

	// Pulses one source; every mask is set, so the pin must never move
	task automatic t_source(input logic g, input int b);
		logic [7:0]  fa, la, m;
		logic [31:0] d;
		logic [1:0]  r;
		fa = g ? `PFI_OFF_MISC_FAULT_FLAGS : `PFI_OFF_BUCK_FAULT_FLAGS;
		la = fa + 8'h08;
		m = 8'h01 << b;
		drive(g, b, 1'b1);
		repeat (5) @(posedge clk);
		u_pfi_host_model.rd(la, d, r);
		chk("live high", d, {24'h0, m});
		u_pfi_host_model.rd(fa, d, r);
		// Completion flag waits for the end of the blow sequence
		chk("flag set", d, {24'h0, (g && b == 6) ? 8'h00 : m});
		chk("pin masked", {31'h0, pin_n}, 32'h1);
		drive(g, b, 1'b0);
		repeat (5) @(posedge clk);
		u_pfi_host_model.rd(la, d, r);
		chk("live low", d, 32'h0);
		u_pfi_host_model.wr(fa, ~m, r);
		u_pfi_host_model.rd(fa, d, r);
		chk("flag sticky", d, {24'h0, m});
		u_pfi_host_model.wr(fa, m, r);
		u_pfi_host_model.rd(fa, d, r);
		chk("flag cleared", d, 32'h0);
		$display("t_source %0d %0d done", g, b);
	endtask

	task automatic t_mask();
		logic [31:0] d;
		logic [1:0]  r;
		u_pfi_host_model.wr(`PFI_OFF_BUCK_FAULT_MASKS, 8'h0b, r);
		u_pfi_host_model.rd(`PFI_OFF_BUCK_FAULT_MASKS, d, r);
		chk("mask readback", d, 32'h0b);
		drive(1'b0, 4, 1'b1);
		repeat (5) @(posedge clk);
		chk("pin unmasked", {31'h0, pin_n}, 32'h0);
		u_pfi_host_model.wr(`PFI_OFF_BUCK_FAULT_MASKS, 8'h1b, r);
		repeat (2) @(posedge clk);
		chk("pin remasked", {31'h0, pin_n}, 32'h1);
		u_pfi_host_model.wr(`PFI_OFF_BUCK_FAULT_MASKS, 8'h0b, r);
		// Live fault keeps setting the flag, so a clear cannot win
		u_pfi_host_model.wr(`PFI_OFF_BUCK_FAULT_FLAGS, 8'h10, r);
		repeat (2) @(posedge clk);
		chk("set beats clear", {31'h0, pin_n}, 32'h0);
		drive(1'b0, 4, 1'b0);
		repeat (5) @(posedge clk);
		u_pfi_host_model.wr(`PFI_OFF_BUCK_FAULT_FLAGS, 8'h10, r);
		@(posedge clk);
		chk("pin after clear", {31'h0, pin_n}, 32'h1);
		u_pfi_host_model.wr(`PFI_OFF_MISC_FAULT_MASKS, 8'h45, r);
		drive(1'b1, 7, 1'b1);
		repeat (5) @(posedge clk);
		chk("pin misc", {31'h0, pin_n}, 32'h0);
		// Fuse error still present, so its clear must lose
		u_pfi_host_model.wr(`PFI_OFF_MISC_FAULT_FLAGS, 8'h80, r);
		repeat (2) @(posedge clk);
		chk("misc set beats clear", {31'h0, pin_n}, 32'h0);
		drive(1'b1, 7, 1'b0);
		u_pfi_host_model.wr(`PFI_OFF_MISC_FAULT_MASKS, 8'hc5, r);
		repeat (2) @(posedge clk);
		chk("pin misc masked", {31'h0, pin_n}, 32'h1);
		$display("t_mask done");
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		for (int b = 0; b < 8; b++) begin
			if (((`PFI_BUCK_BITS >> b) & 8'h01) != 8'h00)
				t_source(1'b0, b);
			if (((`PFI_MISC_BITS >> b) & 8'h01) != 8'h00)
				t_source(1'b1, b);
		end
		t_mask();
		wrap_up();
	end

	// Whole run needs about 400 cycles; generous margin for slow answers
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
endmodule
